// File: design/pcu_pkg.sv
package pcu_pkg;

  localparam int PC_W      = 15;
  localparam int LOW_W     = 8;
  localparam int HIGH_W    = 7;
  localparam int CALL_OP_W = 11;
  localparam int CALL_HI_W = 3;
  localparam int BRA_OFS_W = 9;

  localparam logic [14:0] PC_RESET    = 15'h0000;
  localparam logic [14:0] PC_STEP     = 15'h0001;
  localparam logic [6:0]  LATCH_RESET = 7'h00;

  // one operation per instruction cycle, as issued by the decoder
  typedef enum logic [2:0] {
    OP_NONE,
    OP_WRITE_LOW,
    OP_ADD_LOW,
    OP_CALL_ABS,
    OP_CALL_W,
    OP_BRANCH_W,
    OP_BRANCH_REL
  } pcu_op_t;

  typedef struct packed {
    pcu_op_t     op;
    logic [10:0] operand;
    logic [7:0]  w_val;
    logic [7:0]  wr_data;
    logic        latch_wr;
    logic [6:0]  latch_data;
  } pcu_cmd_t;

  typedef struct packed {
    logic [14:0] target;
    logic        load;
    logic        redirect;
    logic        is_call;
  } pcu_tgt_t;

  function automatic logic [14:0] pcu_sext_ofs(input logic [8:0] ofs);
    pcu_sext_ofs = {{6{ofs[8]}}, ofs};
  endfunction : pcu_sext_ofs

  function automatic logic [14:0] pcu_zext_w(input logic [7:0] w);
    pcu_zext_w = {7'h00, w};
  endfunction : pcu_zext_w

endpackage : pcu_pkg

// File: design/pcu_program_counter.sv
`timescale 1ns/1ps

module pcu_program_counter
  import pcu_pkg::*;
#(
  parameter int PC_WIDTH  = PC_W,
  parameter int LOW_WIDTH = LOW_W,
  parameter int OFS_WIDTH = BRA_OFS_W
)
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire pcu_cmd_t    cmd,
  input  wire logic        step_en,
  output logic [14:0]      fetch_addr,
  output logic [7:0]       pc_low_byte,
  output logic [14:0]      ret_addr,
  output logic             call_push,
  output logic             redirect
);

  // the command struct is built at fixed widths, so other sizes cannot be served
  if (PC_WIDTH != PC_W || LOW_WIDTH != LOW_W || OFS_WIDTH != BRA_OFS_W) begin : g_bad_width
    $error("pcu_program_counter: unsupported width parameter");
  end

  logic [14:0] pc_reg;
  logic [14:0] pc_next;
  logic [6:0]  latch_reg;
  logic [6:0]  latch_next;
  logic [14:0] ret_reg;
  logic [14:0] ret_next;
  logic        push_reg;
  logic        push_next;
  logic        redir_reg;
  logic        redir_next;
  pcu_tgt_t    tgt;

  pcu_target_calc u_target (
    .pc_cur    (pc_reg),
    .latch_cur (latch_reg),
    .cmd       (cmd),
    .step_en   (step_en),
    .tgt       (tgt)
  );

  // counter, return address and pipeline redirect
  always_comb begin
    pc_next    = pc_reg;
    ret_next   = ret_reg;
    push_next  = 1'b0;
    redir_next = 1'b0;
    if (tgt.load) begin
      pc_next = tgt.target;
    end
    if (tgt.is_call) begin
      // the return lands on the instruction after the call
      ret_next  = 15'(pc_reg + PC_STEP);
      push_next = 1'b1;
    end
    redir_next = tgt.redirect;
  end

  // the latch holds only what the decoder writes; the counter never feeds it back
  always_comb begin
    latch_next = latch_reg;
    if (cmd.latch_wr) begin
      latch_next = cmd.latch_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pc_reg    <= PC_RESET;
      latch_reg <= LATCH_RESET;
      ret_reg   <= PC_RESET;
      push_reg  <= 1'b0;
      redir_reg <= 1'b0;
    end else begin
      pc_reg    <= pc_next;
      latch_reg <= latch_next;
      ret_reg   <= ret_next;
      push_reg  <= push_next;
      redir_reg <= redir_next;
    end
  end

  assign fetch_addr  = pc_reg;
  assign pc_low_byte = pc_reg[7:0];
  assign ret_addr    = ret_reg;
  assign call_push   = push_reg;
  assign redirect    = redir_reg;

  // checks on the loading paths, all on the one clock
  default clocking cb @(posedge ref_clk);
  endclocking

  default disable iff (sys_rst);

  reset_clears_pc_a: assert property (
    $fell(sys_rst) |-> (fetch_addr == PC_RESET) && !redirect && !call_push
  ) else $error("counter not zero after reset");

  low_write_load_a: assert property (
    (cmd.op == OP_WRITE_LOW)
      |=> (fetch_addr == {$past(latch_reg), $past(cmd.wr_data)}) && redirect
  ) else $error("low byte write did not load all bits");

  computed_jump_a: assert property (
    (cmd.op == OP_ADD_LOW)
      |=> (pc_low_byte == 8'($past(pc_reg[7:0]) + PC_STEP[7:0] + $past(cmd.w_val)))
          && (fetch_addr[14:8] == $past(latch_reg))
  ) else $error("computed jump target wrong");

  abs_call_load_a: assert property (
    (cmd.op == OP_CALL_ABS)
      |=> (fetch_addr[10:0] == $past(cmd.operand))
          && (fetch_addr[14:11] == $past(latch_reg[6:3]))
          && call_push
          && (ret_addr == 15'($past(pc_reg) + PC_STEP))
  ) else $error("absolute call target or return wrong");

  call_w_load_a: assert property (
    (cmd.op == OP_CALL_W)
      |=> (fetch_addr == {$past(latch_reg), $past(cmd.w_val)}) && call_push
  ) else $error("call via w target wrong");

  branch_w_target_a: assert property (
    (cmd.op == OP_BRANCH_W)
      |=> (fetch_addr == 15'($past(pc_reg) + PC_STEP + {7'h00, $past(cmd.w_val)}))
  ) else $error("branch by w target wrong");

  branch_rel_target_a: assert property (
    (cmd.op == OP_BRANCH_REL)
      |=> (fetch_addr == 15'($past(pc_reg) + PC_STEP
                             + {{6{$past(cmd.operand[8])}}, $past(cmd.operand[8:0])}))
  ) else $error("relative branch target wrong");

  // from the last word of a page the advanced address already sits on the next page,
  // so only a negative relative offset can bring the target back
  branch_page_cross_a: assert property (
    (cmd.op inside {OP_BRANCH_W, OP_BRANCH_REL}) && (pc_reg[7:0] == 8'hff)
      |=> (fetch_addr[14:8] == 7'($past(pc_reg[14:8])
                                  + {6'h00, !(($past(cmd.op) == OP_BRANCH_REL)
                                              && $past(cmd.operand[8]))}))
  ) else $error("branch from page end landed on the wrong page");

  sequential_step_a: assert property (
    (cmd.op == OP_NONE) && step_en
      |=> (fetch_addr == 15'($past(pc_reg) + PC_STEP)) && !redirect && !call_push
  ) else $error("sequential advance wrong");

  hold_when_idle_a: assert property (
    (cmd.op == OP_NONE) && !step_en ##1 (cmd.op == OP_NONE) && !step_en
      |=> $stable(fetch_addr)
  ) else $error("counter moved without a load");

  latch_isolated_a: assert property (
    !cmd.latch_wr && (cmd.op != OP_NONE) |=> $stable(latch_reg)
  ) else $error("latch changed by a counter load");

  low_view_match_a: assert property (
    (cmd.op == OP_WRITE_LOW) |=> (pc_low_byte == $past(cmd.wr_data))
  ) else $error("low byte view does not show written value");

  idle_cycle_hold_a: assert property (
    (cmd.op == OP_NONE) && !step_en |=> $stable(fetch_addr)
  ) else $error("counter moved in an idle cycle");

  step_wrap_a: assert property (
    (cmd.op == OP_NONE) && step_en && (&pc_reg) |=> (fetch_addr == PC_RESET)
  ) else $error("counter did not wrap at the top");

  latch_write_a: assert property (
    cmd.latch_wr |=> (latch_reg == $past(cmd.latch_data))
  ) else $error("latch write not taken");

  latch_idle_hold_a: assert property (
    (cmd.op == OP_NONE) && !cmd.latch_wr |=> $stable(latch_reg)
  ) else $error("latch changed in an idle cycle");

  // pulses and the return address feed the stack outside; it must see them on one edge only
  redirect_kind_a: assert property (
    1'b1 |=> (redirect == ($past(cmd.op) != OP_NONE))
  ) else $error("redirect pulse does not match the load");

  push_only_call_a: assert property (
    !(cmd.op inside {OP_CALL_ABS, OP_CALL_W}) |=> !call_push
  ) else $error("call push without a call");

  ret_addr_hold_a: assert property (
    !(cmd.op inside {OP_CALL_ABS, OP_CALL_W}) |=> $stable(ret_addr)
  ) else $error("return address moved without a call");

  call_w_return_a: assert property (
    (cmd.op == OP_CALL_W) |=> (ret_addr == 15'($past(pc_reg) + PC_STEP)) && redirect
  ) else $error("call via w return address wrong");

  // own disable so that the reset cycles themselves are watched as well
  reset_state_a: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    sys_rst |=> (fetch_addr == PC_RESET) && (ret_addr == PC_RESET)
                && !redirect && !call_push
  ) else $error("reset did not clear the counter");

endmodule : pcu_program_counter

// File: design/pcu_target_calc.sv
`timescale 1ns/1ps

module pcu_target_calc
  import pcu_pkg::*;
(
  input  wire logic [14:0] pc_cur,
  input  wire logic [6:0]  latch_cur,
  input  wire pcu_cmd_t    cmd,
  input  wire logic        step_en,
  output pcu_tgt_t         tgt
);

  logic [14:0] pc_inc;
  logic [7:0]  add_sum;

  // branches and the computed add both start from the already advanced address
  assign pc_inc  = 15'(pc_cur + PC_STEP);
  assign add_sum = 8'(pc_inc[7:0] + cmd.w_val);

  always_comb begin
    tgt = '{target: pc_cur, load: 1'b0, redirect: 1'b0, is_call: 1'b0};
    unique case (cmd.op)
      OP_NONE: begin
        if (step_en) begin
          tgt.target = pc_inc;
          tgt.load   = 1'b1;
        end
      end
      OP_WRITE_LOW: begin
        tgt.target   = {latch_cur, cmd.wr_data};
        tgt.load     = 1'b1;
        tgt.redirect = 1'b1;
      end
      OP_ADD_LOW: begin
        // only the low byte moves: tables across a 256 block need the latch preset
        tgt.target   = {latch_cur, add_sum};
        tgt.load     = 1'b1;
        tgt.redirect = 1'b1;
      end
      OP_CALL_ABS: begin
        tgt.target   = {latch_cur[6:3], cmd.operand};
        tgt.load     = 1'b1;
        tgt.redirect = 1'b1;
        tgt.is_call  = 1'b1;
      end
      OP_CALL_W: begin
        tgt.target   = {latch_cur, cmd.w_val};
        tgt.load     = 1'b1;
        tgt.redirect = 1'b1;
        tgt.is_call  = 1'b1;
      end
      OP_BRANCH_W: begin
        tgt.target   = 15'(pc_inc + pcu_zext_w(cmd.w_val));
        tgt.load     = 1'b1;
        tgt.redirect = 1'b1;
      end
      OP_BRANCH_REL: begin
        tgt.target   = 15'(pc_inc + pcu_sext_ofs(cmd.operand[8:0]));
        tgt.load     = 1'b1;
        tgt.redirect = 1'b1;
      end
      default: begin
        tgt.target = pc_cur;
      end
    endcase
  end

endmodule : pcu_target_calc

// File: verif/pcu_decoder_model.sv
`timescale 1ns/1ps

module pcu_decoder_model
  import pcu_pkg::*;
(
  input  wire logic ref_clk,
  output pcu_cmd_t  cmd,
  output logic      step_en
);
  initial begin
    cmd     = '0;
    step_en = 1'b0;
  end

  // no boundary fix-up for computed tables: the program owns that hazard
  task automatic drive(input pcu_cmd_t c, input logic se);
    @(posedge ref_clk);
    cmd     <= c;
    step_en <= se;
  endtask : drive
endmodule : pcu_decoder_model

// File: verif/program_counter_loading_tb.sv
`timescale 1ns/1ps

module program_counter_loading_tb
  import pcu_pkg::*;
;
  logic        ref_clk;
  logic        sys_rst;
  pcu_cmd_t    cmd;
  pcu_cmd_t    c;
  logic        step_en;
  logic [14:0] fetch_addr;
  logic [7:0]  pc_low_byte;
  logic [14:0] ret_addr;
  logic        call_push;
  logic        redirect;
  logic [15:0] lfsr;
  logic [47:0] raw;
  logic [14:0] m_pc;
  logic [6:0]  m_lat;
  logic [14:0] e_pc;
  logic [14:0] e_ret;
  logic        e_push;
  logic        e_red;
  logic        pend;
  int          errors;
  int          comparisons;
  int          cycles;

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  pcu_decoder_model u_dec (.ref_clk(ref_clk), .cmd(cmd), .step_en(step_en));

  pcu_program_counter DUT (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .cmd        (cmd),
    .step_en    (step_en),
    .fetch_addr (fetch_addr),
    .pc_low_byte(pc_low_byte),
    .ret_addr   (ret_addr),
    .call_push  (call_push),
    .redirect   (redirect)
  );

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [14:0] seen, input logic [14:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic chk_out();
    chk("fetch_addr", fetch_addr, e_pc);
    chk("pc_low_byte", {7'h00, pc_low_byte}, {7'h00, e_pc[7:0]});
    chk("ret_addr", ret_addr, e_ret);
    chk("call_push", {14'h0000, call_push}, {14'h0000, e_push});
    chk("redirect", {14'h0000, redirect}, {14'h0000, e_red});
  endtask : chk_out

  // reference counter; the latch write lands only after the load has used the old value
  task automatic model(input pcu_cmd_t k, input logic se);
    logic [14:0] nx;
    nx = m_pc + 15'h0001;
    e_red = (k.op != OP_NONE);
    e_push = (k.op == OP_CALL_ABS) || (k.op == OP_CALL_W);
    case (k.op)
      OP_NONE:      e_pc = se ? nx : m_pc;
      OP_WRITE_LOW: e_pc = {m_lat, k.wr_data};
      OP_ADD_LOW:   e_pc = {m_lat, nx[7:0] + k.w_val};
      OP_CALL_ABS:  e_pc = {m_lat[6:3], k.operand};
      OP_CALL_W:    e_pc = {m_lat, k.w_val};
      OP_BRANCH_W:  e_pc = nx + {7'h00, k.w_val};
      default:      e_pc = nx + {{6{k.operand[8]}}, k.operand[8:0]};
    endcase
    if (e_push) e_ret = nx;
    if (k.latch_wr) m_lat = k.latch_data;
    m_pc = e_pc;
  endtask : model

  // results of a command show one edge after it is taken, so each check trails by one
  task automatic issue(input pcu_cmd_t k, input logic se);
    u_dec.drive(k, se);
    @(negedge ref_clk);
    if (pend) chk_out();
    model(k, se);
    pend = 1'b1;
  endtask : issue

  task automatic do_reset();
    u_dec.drive('0, 1'b0);
    sys_rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    {m_pc, m_lat, e_pc, e_ret, e_push, e_red, pend} = '0;
    chk_out();
  endtask : do_reset

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    sys_rst = 1'b1;
    lfsr = 16'h004e;
    {errors, comparisons, cycles, pend} = '0;
    do_reset();
    c = '0;
    c.latch_wr = 1'b1;
    c.latch_data = 7'h7f;
    issue(c, 1'b0);
    c = '0;
    c.op = OP_WRITE_LOW;
    c.wr_data = 8'hff;
    issue(c, 1'b0);
    issue('0, 1'b1);
    c = '0;
    c.op = OP_WRITE_LOW;
    c.wr_data = 8'h10;
    c.latch_wr = 1'b1;
    c.latch_data = 7'h2a;
    issue(c, 1'b0);
    c = '0;
    c.op = OP_CALL_ABS;
    c.operand = 11'h7ff;
    issue(c, 1'b0);
    c.op = OP_BRANCH_REL;
    c.operand = 11'h100;
    issue(c, 1'b0);
    c.op = OP_BRANCH_W;
    c.w_val = 8'hff;
    issue(c, 1'b0);
    for (int i = 0; i < 600; i++) begin
      raw[15:0] = rnd();
      raw[31:16] = rnd();
      raw[47:32] = rnd();
      c = pcu_cmd_t'(raw[37:0]);
      c.op = pcu_op_t'(3'(raw[47:40] % 8'h07));
      issue(c, raw[38]);
      if (i == 300) do_reset();
    end
    issue('0, 1'b0);
    tally_and_finish();
  end
endmodule : program_counter_loading_tb
